/* rtl/mct_cfg.svh */
`ifndef MCT_CFG_SVH
`define MCT_CFG_SVH
// Contract
// RQ1: each channel has a 3-bit clock-select field in control bits 2..0, reset to zero; the code has no such field for channel 0.
// RQ2: on channels 1 to 5, codes 000 to 011 count the system clock divided by 1, 4, 16 and 64.
// RQ3: channel 1 codes 100/101 count pins A/B, 110 is clock/256, 111 is channel 2 wrap.
// RQ4: channel 1 on code 111 increments once per overflow or underflow of channel 2.
// RQ5: channel 2 codes 100..110 count pins A, B, C, 111 is clock/1024; ignored in phase mode.
// RQ6: channel 3 code 100 counts pin A, codes 101, 110, 111 are clock/1024, /256, /4096.
// RQ7: channel 4 codes 100/101 count pins A/C, 110 is clock/1024, 111 is channel 5 wrap.
// RQ8: channel 5 codes 100/101 count pins A/C, 110 is clock/256, 111 counts pin D.
// RQ9: in phase counting mode channel 1 ignores its clock-select field.
// RQ10: in phase counting mode channels 4 and 5 ignore their clock-select field.
// RQ11: there are six 8-bit read/write mode registers, one per channel.
// RQ12: software should change a mode register only while that counter is stopped.
// RQ13: mode 0000 is normal, 0010/0011 are the two pwm modes, 0100..0111 phase modes 1..4.
// RQ14: external pins are synchronised before edge detection so each edge counts once.
`define MCT_NCH          6
`define MCT_CSEL_MSB     2
`define MCT_CSEL_RST     3'h0
`define MCT_MODE_RST     8'h00
`define MCT_MD_PHASE_BIT 2
`define MCT_PRE_W        12
`endif

/* rtl/mct_pkg.sv */
package mct_pkg;
  typedef enum logic [3:0] {
    MCT_MD_NORMAL = 4'h0,
    MCT_MD_PWM1   = 4'h2,
    MCT_MD_PWM2   = 4'h3,
    MCT_MD_PHASE1 = 4'h4,
    MCT_MD_PHASE2 = 4'h5,
    MCT_MD_PHASE3 = 4'h6,
    MCT_MD_PHASE4 = 4'h7
  } mct_mode_t;
  // count sources after per-channel decode
  typedef enum logic [3:0] {
    MCT_SRC_D1, MCT_SRC_D4, MCT_SRC_D16, MCT_SRC_D64, MCT_SRC_D256,
    MCT_SRC_D1024, MCT_SRC_D4096, MCT_SRC_PA, MCT_SRC_PB, MCT_SRC_PC,
    MCT_SRC_PD, MCT_SRC_CASC
  } mct_src_t;
endpackage

/* rtl/mct_tick_if.sv */
`timescale 1ns/10ps
interface mct_tick_if;
  logic [6:0] pre_tick; // /1 /4 /16 /64 /256 /1024 /4096
  logic [3:0] pin_edge; // a b c d
  modport src (output pre_tick, output pin_edge);
  modport snk (input pre_tick, input pin_edge);
endinterface

/* rtl/mct_tick_gen.sv */
`timescale 1ns/10ps
`include "mct_cfg.svh"
module mct_tick_gen (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_b,
  // edge selection shared by all four pins: 00 rising, 01 falling, 1x both
  input  wire logic [1:0] i_edge_sel,
  // raw pins a..d
  input  wire logic [3:0] i_pins,
  mct_tick_if.src         tk
);
  logic [`MCT_PRE_W-1:0] pre;
  logic [3:0]            sync1;
  logic [3:0]            sync2;
  logic [3:0]            last;

  // free-running prescaler
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) pre <= '0;
    else pre <= pre + 12'h001;
  end

  // one tick per all-ones wrap of each tap
  assign tk.pre_tick[0] = 1'b1;
  genvar g;
  generate
    for (g = 1; g < 7; g++) begin : g_tap
      assign tk.pre_tick[g] = &pre[2*g-1:0];
    end
  endgenerate

  // two flops before edge logic; sync1 feeds sync2 only
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      last  <= 4'h0;
    end else begin
      sync1 <= i_pins; // RQ14
      sync2 <= sync1;
      last  <= sync2;
    end
  end

  generate
    for (g = 0; g < 4; g++) begin : g_edge
      assign tk.pin_edge[g] = i_edge_sel[1] ? (sync2[g] ^ last[g]) :
                              i_edge_sel[0] ? (last[g] & ~sync2[g]) :
                                              (sync2[g] & ~last[g]); // RQ14
    end
  endgenerate
endmodule

/* rtl/mct_clk_select.sv */
`timescale 1ns/10ps
`include "mct_cfg.svh"
module mct_clk_select (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_b,
  // external count pins
  input  wire logic        i_ext_count_pin_a,
  input  wire logic        i_ext_count_pin_b,
  input  wire logic        i_ext_count_pin_c,
  input  wire logic        i_ext_count_pin_d,
  // control field write, per channel index 1..5
  input  wire logic        i_csel_wr,
  input  wire logic [2:0]  i_csel_ch,
  input  wire logic [2:0]  i_csel_data,
  input  wire logic [1:0]  i_edge_sel,
  // mode register write, channel 0..5
  input  wire logic        i_mode_wr,
  input  wire logic [2:0]  i_mode_ch,
  input  wire logic [7:0]  i_mode_data,
  // counter run enables, channels 0..5
  input  wire logic [5:0]  i_run,
  // phase-mode count pulses from the quadrature decoder, channels 0..5
  input  wire logic [5:0]  i_phase_tick,
  input  wire logic [5:0]  i_phase_down,
  // readback
  input  wire logic [2:0]  i_rd_ch,
  output logic      [2:0]  o_csel_rd,
  output logic      [7:0]  o_mode_rd,
  // counters and count strobes
  output logic      [15:0] o_cnt1,
  output logic      [15:0] o_cnt2,
  output logic      [15:0] o_cnt3,
  output logic      [15:0] o_cnt4,
  output logic      [15:0] o_cnt5,
  output logic      [5:1]  o_count_en,
  output logic      [5:1]  o_wrap
);
  mct_tick_if tk ();

  logic [2:0]  clk_sel [1:5];
  logic [7:0]  channel_mode_register [0:5];
  logic [15:0] channel_counter [1:5];
  logic [5:1]  cnt_en;
  logic [5:1]  dir_dn;
  logic [5:1]  wrap_now;

  mct_tick_gen u_tick (
    .i_ref_clk  (i_ref_clk),
    .i_rst_b    (i_rst_b),
    .i_edge_sel (i_edge_sel),
    .i_pins     ({i_ext_count_pin_d, i_ext_count_pin_c,
                  i_ext_count_pin_b, i_ext_count_pin_a}),
    .tk         (tk)
  );

  // per-channel code-to-source decode, used by channels 1 to 5
  function automatic mct_pkg::mct_src_t f_src(input logic [2:0] ch, input logic [2:0] c);
    mct_pkg::mct_src_t s;
    s = mct_pkg::MCT_SRC_D1;
    unique case (c)
      3'h0: s = mct_pkg::MCT_SRC_D1;  // RQ2
      3'h1: s = mct_pkg::MCT_SRC_D4;  // RQ2
      3'h2: s = mct_pkg::MCT_SRC_D16; // RQ2
      3'h3: s = mct_pkg::MCT_SRC_D64; // RQ2
      3'h4: s = mct_pkg::MCT_SRC_PA;
      3'h5: s = (ch == 3'h1) ? mct_pkg::MCT_SRC_PB :
                (ch == 3'h2) ? mct_pkg::MCT_SRC_PB :
                (ch == 3'h3) ? mct_pkg::MCT_SRC_D1024 : mct_pkg::MCT_SRC_PC; // RQ6
      3'h6: s = (ch == 3'h1) ? mct_pkg::MCT_SRC_D256 :
                (ch == 3'h2) ? mct_pkg::MCT_SRC_PC :
                (ch == 3'h3) ? mct_pkg::MCT_SRC_D256 :
                (ch == 3'h4) ? mct_pkg::MCT_SRC_D1024 : mct_pkg::MCT_SRC_D256; // RQ5
      3'h7: s = (ch == 3'h1) ? mct_pkg::MCT_SRC_CASC :
                (ch == 3'h2) ? mct_pkg::MCT_SRC_D1024 :
                (ch == 3'h3) ? mct_pkg::MCT_SRC_D4096 :
                (ch == 3'h4) ? mct_pkg::MCT_SRC_CASC : mct_pkg::MCT_SRC_PD; // RQ8
    endcase
    return s;
  endfunction

  // phase counting is mode 01xx; reserved bit 3 must be clear
  function automatic logic f_phase(input logic [7:0] m);
    return (m[3:`MCT_MD_PHASE_BIT] == 2'b01); // RQ13
  endfunction

  // clock-select fields
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      for (int i = 1; i <= 5; i++) clk_sel[i] <= `MCT_CSEL_RST; // RQ1
    end else if (i_csel_wr && i_csel_ch >= 3'h1 && i_csel_ch <= 3'h5) begin
      clk_sel[i_csel_ch] <= i_csel_data; // RQ1
    end
  end

  // six mode registers; writes while running are accepted, software must stop first
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      for (int i = 0; i < `MCT_NCH; i++) channel_mode_register[i] <= `MCT_MODE_RST; // RQ11
    end else if (i_mode_wr && i_mode_ch <= 3'h5) begin
      channel_mode_register[i_mode_ch] <= i_mode_data; // RQ11
    end
  end

  // count-enable selection per channel
  always_comb begin
    for (int i = 1; i <= 5; i++) begin
      mct_pkg::mct_src_t s;
      logic              t;
      s = f_src(3'(i), clk_sel[i]);
      t = 1'b0;
      unique case (s)
        mct_pkg::MCT_SRC_D1:    t = tk.pre_tick[0];
        mct_pkg::MCT_SRC_D4:    t = tk.pre_tick[1];
        mct_pkg::MCT_SRC_D16:   t = tk.pre_tick[2];
        mct_pkg::MCT_SRC_D64:   t = tk.pre_tick[3];
        mct_pkg::MCT_SRC_D256:  t = tk.pre_tick[4]; // RQ3
        mct_pkg::MCT_SRC_D1024: t = tk.pre_tick[5]; // RQ7
        mct_pkg::MCT_SRC_D4096: t = tk.pre_tick[6]; // RQ6
        mct_pkg::MCT_SRC_PA:    t = tk.pin_edge[0];
        mct_pkg::MCT_SRC_PB:    t = tk.pin_edge[1]; // RQ3
        mct_pkg::MCT_SRC_PC:    t = tk.pin_edge[2]; // RQ7
        mct_pkg::MCT_SRC_PD:    t = tk.pin_edge[3]; // RQ8
        mct_pkg::MCT_SRC_CASC:  t = (i == 1) ? wrap_now[2] : wrap_now[5]; // RQ4 RQ7
        default:                t = 1'b0;
      endcase
      dir_dn[i] = 1'b0;
      // phase mode hands the counter to the quadrature pulses
      if (f_phase(channel_mode_register[i])) begin
        t = i_phase_tick[i]; // RQ9 RQ10
        dir_dn[i] = i_phase_down[i];
      end
      cnt_en[i] = i_run[i] & t;
    end
  end

  // wrap happens on the count step that passes all-ones up or zero down
  always_comb begin
    for (int i = 1; i <= 5; i++) begin
      wrap_now[i] = cnt_en[i] & (dir_dn[i] ? (channel_counter[i] == 16'h0000)
                                           : (channel_counter[i] == 16'hFFFF));
    end
  end

  // counters; the cascade uses a combinational wrap so 1 and 4 step in the same edge as 2 and 5 wrap
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      for (int i = 1; i <= 5; i++) channel_counter[i] <= 16'h0000;
    end else begin
      for (int i = 1; i <= 5; i++) begin
        if (cnt_en[i]) begin
          channel_counter[i] <= dir_dn[i] ? channel_counter[i] - 16'h0001
                                          : channel_counter[i] + 16'h0001; // RQ4
        end
      end
    end
  end

  // registered strobes and readback
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_count_en <= 5'h00;
      o_wrap     <= 5'h00;
      o_csel_rd  <= 3'h0;
      o_mode_rd  <= 8'h00;
    end else begin
      o_count_en <= cnt_en;
      o_wrap     <= wrap_now;
      o_csel_rd  <= (i_rd_ch >= 3'h1 && i_rd_ch <= 3'h5) ? clk_sel[i_rd_ch] : 3'h0;
      o_mode_rd  <= (i_rd_ch <= 3'h5) ? channel_mode_register[i_rd_ch] : 8'h00;
    end
  end

  assign o_cnt1 = channel_counter[1];
  assign o_cnt2 = channel_counter[2];
  assign o_cnt3 = channel_counter[3];
  assign o_cnt4 = channel_counter[4];
  assign o_cnt5 = channel_counter[5];
endmodule

/* tb/mct_clk_select_checker.sv */
`timescale 1ns/10ps
module mct_clk_select_checker (
  // clock, reset and setup writes
  input wire logic        i_ref_clk,
  input wire logic        i_rst_b,
  input wire logic        i_csel_wr,
  input wire logic [2:0]  i_csel_ch,
  input wire logic [2:0]  i_csel_data,
  input wire logic        i_mode_wr,
  input wire logic [2:0]  i_mode_ch,
  input wire logic [7:0]  i_mode_data,
  input wire logic [5:0]  i_run,
  input wire logic [5:0]  i_phase_tick,
  input wire logic [2:0]  i_rd_ch,
  // observed outputs
  input wire logic [2:0]  o_csel_rd,
  input wire logic [15:0] o_cnt1,
  input wire logic [15:0] o_cnt2,
  input wire logic [5:1]  o_count_en,
  input wire logic [5:1]  o_wrap
);
  logic [2:0] csel1;
  logic       ph1;
  // shadow of channel 1 setup, so source checks know what was selected
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      csel1 <= 3'h0;
      ph1   <= 1'b0;
    end else begin
      if (i_csel_wr && i_csel_ch == 3'h1) csel1 <= i_csel_data;
      if (i_mode_wr && i_mode_ch == 3'h1) ph1 <= (i_mode_data[3:2] == 2'b01);
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  chk_reset_zero: assert property (
    $rose(i_rst_b) |-> o_csel_rd == 3'h0 && o_count_en == 5'h0)
    else $error("outputs not clear after reset");
  chk_csel_read: assert property (
    i_csel_wr && i_csel_ch inside {[3'h1:3'h5]} ##1 i_rd_ch == $past(i_csel_ch)
    |=> o_csel_rd == $past(i_csel_data, 2)) else $error("select readback wrong");
  chk_csel_refuse: assert property (
    $past(i_rd_ch) inside {3'h0, 3'h6, 3'h7} |-> o_csel_rd == 3'h0)
    else $error("select slot without channel not zero");
  chk_count_step: assert property (
    $past(i_rst_b) && o_cnt1 != $past(o_cnt1) |-> o_count_en[1])
    else $error("counter moved without strobe");
  chk_div_one: assert property (
    (csel1 == 3'h0 && !ph1 && i_run[1]) [*2] |=> o_count_en[1])
    else $error("divide by one missed a cycle");
  chk_casc_step: assert property (
    o_wrap[2] && $past(csel1 == 3'h7 && !ph1 && i_run[1]) |-> o_count_en[1])
    else $error("cascade step missed");
  chk_wrap_flag: assert property (
    $past(i_rst_b) && $past(o_cnt2) == 16'hFFFF && o_cnt2 == 16'h0 |-> o_wrap[2])
    else $error("overflow not flagged");
  chk_phase_hold: assert property (
    (ph1 && !i_phase_tick[1]) [*2] |=> !o_count_en[1])
    else $error("phase mode counted without pulse");
endmodule
bind mct_clk_select mct_clk_select_checker u_mct_clk_select_checker (
  .i_ref_clk, .i_rst_b, .i_csel_wr, .i_csel_ch, .i_csel_data, .i_mode_wr, .i_mode_ch,
  .i_mode_data, .i_run, .i_phase_tick, .i_rd_ch, .o_csel_rd, .o_cnt1, .o_cnt2,
  .o_count_en, .o_wrap);

/* tb/mct_clk_select_bench.sv */
`timescale 1ns/10ps
module mct_clk_select_bench;
  logic        i_ref_clk, i_rst_b, i_csel_wr, i_mode_wr;
  logic [2:0]  i_csel_ch, i_csel_data, i_mode_ch, i_rd_ch, o_csel_rd;
  logic [7:0]  i_mode_data, o_mode_rd;
  logic [1:0]  i_edge_sel;
  logic [3:0]  pins;
  logic [5:0]  i_run, i_phase_tick, i_phase_down;
  logic [5:1]  o_count_en;
  logic [5:1]  o_wrap;
  wire  [15:0] cnt [1:5];
  logic [31:0] seed = 32'hC0EA;
  logic [15:0] s, t;
  int          mismatches, checked, e, p, n;
  mct_clk_select u_mct_clk_select (
    .i_ref_clk, .i_rst_b, .i_ext_count_pin_a(pins[0]), .i_ext_count_pin_b(pins[1]),
    .i_ext_count_pin_c(pins[2]), .i_ext_count_pin_d(pins[3]), .i_csel_wr, .i_csel_ch,
    .i_csel_data, .i_edge_sel, .i_mode_wr, .i_mode_ch, .i_mode_data, .i_run, .i_phase_tick,
    .i_phase_down, .i_rd_ch, .o_csel_rd, .o_mode_rd, .o_cnt1(cnt[1]), .o_cnt2(cnt[2]),
    .o_cnt3(cnt[3]), .o_cnt4(cnt[4]), .o_cnt5(cnt[5]), .o_count_en, .o_wrap);
  always #20 i_ref_clk = ~i_ref_clk;
  // hard stop far beyond the longest expected run
  initial begin
    #3900000 mismatches++;
    finish_test();
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // count source per code: divisor, 0 for cascade, -1..-4 for pins a..d
  function automatic int src(input int c, input int k);
    if (k < 4) return 1 << (2 * k);
    case (c * 8 + k)
      12, 20, 28, 36, 44: return -1;
      13, 21: return -2;
      22, 37, 45: return -3;
      47: return -4;
      15, 39: return 0;
      14, 30, 46: return 256;
      23, 29, 38: return 1024;
      default: return 4096;
    endcase
  endfunction
  task automatic tk(input int k);
    repeat (k) @(negedge i_ref_clk);
  endtask
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one write strobe, either the select field or the mode register;
  // a mode write stops the counters for its edge, then one idle cycle follows
  task automatic wr(input bit m, input logic [2:0] c, input logic [7:0] d);
    logic [5:0] r;
    r = i_run;
    if (m) i_run = 6'h00;
    {i_csel_wr, i_mode_wr, i_csel_ch, i_mode_ch} = {!m, m, c, c};
    {i_csel_data, i_mode_data} = {d[2:0], d};
    tk(1);
    {i_csel_wr, i_mode_wr} = 2'b00;
    if (m) i_run = r;
    tk(1);
  endtask
  task automatic rd(input logic [2:0] c, input logic [2:0] ec, input logic [7:0] em);
    i_rd_ch = c;
    tk(2);
    cmp("csel", 16'(ec), 16'(o_csel_rd));
    cmp("mode", 16'(em), 16'(o_mode_rd));
  endtask
  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    {i_ref_clk, i_rst_b, i_csel_wr, i_mode_wr, i_csel_ch, i_csel_data, i_mode_ch} = '0;
    {i_rd_ch, i_mode_data, i_edge_sel, pins, i_run, i_phase_tick, i_phase_down} = '0;
    tk(8);
    i_rst_b = 1'b1;
    // every slot reads zero from reset, then keeps random data if it exists
    for (int c = 0; c < 8; c++) begin
      s = 16'(xs());
      rd(3'(c), 3'h0, 8'h00);
      wr(0, 3'(c), s[7:0]);
      wr(1, 3'(c), s[15:8]);
      rd(3'(c), (c inside {[1:5]}) ? s[2:0] : 3'h0, (c < 6) ? s[15:8] : 8'h00);
    end
    // channels 2 and 5 in phase mode step down through zero and back up
    wr(0, 3'h1, 8'h07);
    wr(0, 3'h4, 8'h07);
    for (int c = 1; c < 6; c++) wr(1, 3'(c), (c % 3 == 2) ? 8'h04 : 8'h00);
    i_run = 6'h3E;
    tk(1);
    for (int k = 0; k < 2; k++) begin
      {i_phase_tick, i_phase_down} = {6'h24, k ? 6'h00 : 6'h24};
      tk(1);
      cmp("wrap", 16'h0012, 16'(o_wrap));
      i_phase_tick = 6'h00;
      tk(4);
      cmp("cnt2", k ? 16'h0 : 16'hFFFF, cnt[2]);
      cmp("cnt5", k ? 16'h0 : 16'hFFFF, cnt[5]);
      cmp("cnt1", 16'(k + 1), cnt[1]);
      cmp("cnt4", 16'(k + 1), cnt[4]);
    end
    // phase modes on 1 and 4: the divide-by-one select must not count
    for (int m = 4; m < 8; m++) begin
      wr(1, 3'h1, 8'(m));
      wr(1, 3'h4, 8'(m));
      wr(0, 3'h1, 8'h00);
      wr(0, 3'h4, 8'h00);
      {s, t} = {cnt[1], cnt[4]};
      tk(6);
      cmp("cnt1 idle", s, cnt[1]);
      cmp("cnt4 idle", t, cnt[4]);
      {i_phase_tick, i_phase_down} = {6'h12, {6{m[0]}}};
      tk(2);
      i_phase_tick = 6'h00;
      tk(2);
      cmp("cnt1 phase", m[0] ? s - 16'h2 : s + 16'h2, cnt[1]);
      cmp("cnt4 phase", m[0] ? t - 16'h2 : t + 16'h2, cnt[4]);
    end
    // every code of channels 1 to 5 except cascade code 111 of 1 and 4, each in one mode: normal, pwm1 or pwm2 by code mod 3
    for (int c = 1; c < 6; c++) begin
      for (int k = 0; k < 8; k++) begin
        e = src(c, k);
        if (e == 0) continue;
        wr(1, 3'(c), 8'(k % 3 == 0 ? 0 : 1 + k % 3));
        wr(0, 3'(c), 8'(k));
        tk(8);
        {s, n, p} = {cnt[c], 32'h0, 32'(-e - 1)};
        if (e > 0) begin
          repeat (4 * e) begin
            tk(1);
            n += int'(o_count_en[c]);
          end
          cmp("strobes", 16'h4, 16'(n));
          cmp("count", s + 16'h4, cnt[c]);
        end else begin
          i_edge_sel = 2'(xs() % 3);
          repeat (12) begin
            t = 16'(xs());
            n += int'((t[p] && !pins[p] && i_edge_sel != 2'h1) ||
                      (!t[p] && pins[p] && i_edge_sel != 2'h0));
            pins = t[3:0];
            tk(3);
          end
          tk(5);
          cmp("edges", s + 16'(n), cnt[c]);
        end
      end
    end
    finish_test();
  end
endmodule
